// file: inc/data_space_access_align_params.svh
// constants for the data-space access alignment block
`ifndef DATA_SPACE_ACCESS_ALIGN_PARAMS_SVH
`define DATA_SPACE_ACCESS_ALIGN_PARAMS_SVH
`define DSA_ADDR_W 16
`define DSA_DATA_W 16
`define DSA_WORD_ADDR_W 15
`define DSA_ZERO_WORD 16'h0000
`define DSA_STEP_BYTE 16'h0001
`define DSA_STEP_WORD 16'h0002
`define DSA_Y_BASE_DEFAULT 16'h0800
`define DSA_Y_END_DEFAULT 16'h0bff
`define DSA_IMPL_END_DEFAULT 16'h0bff
`define DSA_X_HIGH_BASE_DEFAULT 16'h8000
`endif

// file: inc/data_space_access_align_pkg.sv
// types for the data-space access alignment block
package data_space_access_align_pkg;
	typedef enum logic [1:0] {
		PTR_X_FIRST,
		PTR_X_SECOND,
		PTR_Y_FIRST,
		PTR_Y_SECOND
	} prefetch_ptr_t;
endpackage

// file: hdl/data_space_access_align.sv
// data-space address resolution, byte steering and alignment traps
`timescale 1ns/1ps
`include "data_space_access_align_params.svh"

module data_space_access_align #(
	parameter logic [15:0] Y_BASE = `DSA_Y_BASE_DEFAULT,
	parameter logic [15:0] Y_END = `DSA_Y_END_DEFAULT,
	parameter logic [15:0] IMPL_END = `DSA_IMPL_END_DEFAULT,
	parameter logic [15:0] X_HIGH_BASE = `DSA_X_HIGH_BASE_DEFAULT
) (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic clk_en,
	// x port: reads and all writes
	input wire logic x_req,
	input wire logic x_write,
	input wire logic x_byte,
	input wire logic [15:0] x_effective_address,
	input wire logic [15:0] x_wdata,
	input wire logic [15:0] source_pointer_register,
	input wire logic x_post_inc,
	// y port and x prefetch select: dual_operand_multiply_class word prefetch
	input wire logic y_req,
	input wire logic [15:0] y_effective_address,
	input wire data_space_access_align_pkg::prefetch_ptr_t y_ptr_sel,
	input wire logic x_prefetch,
	input wire data_space_access_align_pkg::prefetch_ptr_t x_ptr_sel,
	// memory side
	input wire logic [15:0] mem_x_rdata,
	input wire logic [15:0] mem_y_rdata,
	output logic [14:0] mem_x_word_addr,
	output logic [14:0] mem_y_word_addr,
	output logic mem_x_rd,
	output logic mem_y_rd,
	output logic [1:0] mem_x_lane_we,
	output logic [15:0] mem_x_wdata,
	// results to requester
	output logic [15:0] x_rdata,
	output logic x_rvalid,
	output logic [15:0] y_rdata,
	output logic y_rvalid,
	output logic [15:0] pointer_updated,
	output logic address_error_trap
);
	import data_space_access_align_pkg::*;

	// ------------------------------------------------------------
	// address classification
	// ------------------------------------------------------------
	function automatic logic in_y_space(input logic [15:0] a);
		in_y_space = (a >= Y_BASE) && (a <= Y_END);
	endfunction

	function automatic logic implemented(input logic [15:0] a);
		implemented = (a <= IMPL_END) || (a >= X_HIGH_BASE);
	endfunction

	function automatic logic is_x_ptr(input prefetch_ptr_t p);
		is_x_ptr = (p == PTR_X_FIRST) || (p == PTR_X_SECOND);
	endfunction

	logic x_misaligned;
	logic x_valid_read;
	logic y_valid_read;
	logic x_sel_odd_r;
	logic x_byte_r;
	logic x_zero_r;
	logic y_zero_r;
	logic x_pend_r;
	logic y_pend_r;

	assign x_misaligned = !x_byte && x_effective_address[0];
	// prefetch pointers stay in their own space, in both directions
	// an x pointer into y space and a y pointer outside y space both read zero
	assign x_valid_read = implemented(x_effective_address)
		&& !(x_prefetch && is_x_ptr(x_ptr_sel) && in_y_space(x_effective_address))
		&& !(x_prefetch && !is_x_ptr(x_ptr_sel) && !in_y_space(x_effective_address));
	// y-pointer prefetch must stay in y space; x pointers on the y bus also invalid
	assign y_valid_read = implemented(y_effective_address)
		&& in_y_space(y_effective_address) && !is_x_ptr(y_ptr_sel);

	// ------------------------------------------------------------
	// memory request stage
	// ------------------------------------------------------------
	// address and strobes are registered so the memory sees a clean cycle
	// write data is replicated for byte writes; the lane enable picks the side
	// a misaligned word write keeps both lanes shut, the trap still follows
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_x_word_addr <= 15'h0000;
			mem_x_rd <= 1'b0;
			mem_x_lane_we <= 2'h0;
			mem_x_wdata <= `DSA_ZERO_WORD;
		end else if (clk_en) begin
			mem_x_word_addr <= x_effective_address[15:1];
			mem_x_rd <= x_req && !x_write;
			if (x_req && x_write && !x_misaligned) begin
				if (x_byte) begin
					mem_x_lane_we <= x_effective_address[0] ? 2'h2 : 2'h1;
					mem_x_wdata <= {x_wdata[7:0], x_wdata[7:0]};
				end else begin
					mem_x_lane_we <= 2'h3;
					mem_x_wdata <= x_wdata;
				end
			end else begin
				mem_x_lane_we <= 2'h0;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			mem_y_word_addr <= 15'h0000;
			mem_y_rd <= 1'b0;
		end else if (clk_en) begin
			mem_y_word_addr <= y_effective_address[15:1];
			mem_y_rd <= y_req;
		end
	end

	// ------------------------------------------------------------
	// request context carried to the return stage
	// ------------------------------------------------------------
	// context is registered on the same edge as the memory strobe so it lines up
	// with the data that the memory returns on the following edge
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			x_pend_r <= 1'b0;
			y_pend_r <= 1'b0;
			x_sel_odd_r <= 1'b0;
			x_byte_r <= 1'b0;
			x_zero_r <= 1'b0;
			y_zero_r <= 1'b0;
		end else if (clk_en) begin
			x_pend_r <= x_req && !x_write;
			y_pend_r <= y_req;
			x_sel_odd_r <= x_effective_address[0];
			x_byte_r <= x_byte;
			x_zero_r <= !x_valid_read;
			y_zero_r <= !y_valid_read;
		end
	end

	// ------------------------------------------------------------
	// read return with byte steering
	// ------------------------------------------------------------
	// idle cycles force zero so stale memory data never leaks out
	// the selected byte always lands on the low lane, upper byte zero
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			x_rdata <= `DSA_ZERO_WORD;
			x_rvalid <= 1'b0;
		end else if (clk_en) begin
			x_rvalid <= x_pend_r; // misaligned read still completes
			if (!x_pend_r || x_zero_r) begin
				x_rdata <= `DSA_ZERO_WORD;
			end else if (x_byte_r) begin
				x_rdata <= {8'h00, x_sel_odd_r ? mem_x_rdata[15:8] : mem_x_rdata[7:0]};
			end else begin
				x_rdata <= mem_x_rdata;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			y_rdata <= `DSA_ZERO_WORD;
			y_rvalid <= 1'b0;
		end else if (clk_en) begin
			y_rvalid <= y_pend_r;
			y_rdata <= (!y_pend_r || y_zero_r) ? `DSA_ZERO_WORD : mem_y_rdata;
		end
	end

	// ------------------------------------------------------------
	// pointer post-modification and trap
	// ------------------------------------------------------------
	// step follows the access size so pointers walk word-aligned memory
	// trap is a single pulse; the core decides when to take it
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			pointer_updated <= `DSA_ZERO_WORD;
		end else if (clk_en) begin
			if (x_post_inc) begin
				pointer_updated <= source_pointer_register
					+ (x_byte ? `DSA_STEP_BYTE : `DSA_STEP_WORD);
			end else begin
				pointer_updated <= source_pointer_register;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			address_error_trap <= 1'b0;
		end else if (clk_en) begin
			address_error_trap <= x_req && x_misaligned;
		end
	end
endmodule // data_space_access_align

// file: tb/dsa_properties.sv
// checker for the data-space alignment block
`timescale 1ns/1ps
module dsa_properties (
	input wire logic sys_clk,
	input wire logic rst_n,
	input wire logic x_req,
	input wire logic x_write,
	input wire logic x_byte,
	input wire logic [15:0] x_effective_address,
	input wire logic [15:0] source_pointer_register,
	input wire logic x_post_inc,
	input wire logic y_req,
	input wire logic [1:0] mem_x_lane_we,
	input wire logic x_rvalid,
	input wire logic [15:0] x_rdata,
	input wire logic [15:0] pointer_updated,
	input wire logic address_error_trap
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	wire odd_w = x_req && !x_byte && x_effective_address[0];
	trap_odd_a: assert property (odd_w |=> address_error_trap) else $error("no trap");
	trap_clean_a: assert property (x_req && !odd_w |=> !address_error_trap)
		else $error("bad trap");
	write_drop_a: assert property (odd_w && x_write |=> mem_x_lane_we == 2'b00)
		else $error("odd write");
	byte_lane_a: assert property (x_req && x_write && x_byte
		|=> mem_x_lane_we == ($past(x_effective_address[0]) ? 2'b10 : 2'b01))
		else $error("byte lane");
	word_lane_a: assert property (x_req && x_write && !x_byte && !odd_w
		|=> mem_x_lane_we == 2'b11) else $error("word lanes");
	ptr_step_a: assert property (x_req && x_post_inc |=> pointer_updated ==
		$past(source_pointer_register) + ($past(x_byte) ? 16'h0001 : 16'h0002))
		else $error("pointer step");
	read_lat_a: assert property (x_req && !x_write |-> ##2 x_rvalid) else $error("late");
	byte_hi_a: assert property (x_req && !x_write && x_byte |-> ##2 x_rdata[15:8] == 8'h00)
		else $error("byte upper");
	y_read_only_a: assert property (y_req && !x_req |=> mem_x_lane_we == 2'b00)
		else $error("y write");
endmodule // dsa_properties

// file: tb/data_mem_model.sv
// two-lane word memory behind the block
`timescale 1ns/1ps
module data_mem_model (
	input wire logic sys_clk,
	input wire logic [14:0] mem_x_word_addr,
	input wire logic [14:0] mem_y_word_addr,
	input wire logic mem_x_rd,
	input wire logic mem_y_rd,
	input wire logic [1:0] mem_x_lane_we,
	input wire logic [15:0] mem_x_wdata,
	output logic [15:0] mem_x_rdata,
	output logic [15:0] mem_y_rdata
);
	logic [15:0] m [0:32767];
	logic tog = 1'b0;
	initial for (int i = 0; i < 32768; i++) m[i] = 16'(i * 40503);
	// unselected read data keeps changing
	assign mem_x_rdata = mem_x_rd ? m[mem_x_word_addr] : {16{tog}} ^ 16'h3c5a;
	assign mem_y_rdata = mem_y_rd ? m[mem_y_word_addr] : {16{tog}} ^ 16'h5ac3;
	always @(posedge sys_clk) begin
		tog <= ~tog;
		if (mem_x_lane_we[0]) m[mem_x_word_addr][7:0] <= mem_x_wdata[7:0];
		if (mem_x_lane_we[1]) m[mem_x_word_addr][15:8] <= mem_x_wdata[15:8];
	end
endmodule // data_mem_model

// file: tb/testbench.sv
// random traffic against a reference data space
`timescale 1ns/1ps
module testbench;
	import data_space_access_align_pkg::*;
	logic sys_clk = 0, rst_n = 0, clk_en = 1, x_req = 0, x_write = 0, x_byte = 0;
	logic x_post_inc = 0, y_req = 0, x_prefetch = 0;
	logic [15:0] x_effective_address = 0, x_wdata = 0, source_pointer_register = 0;
	logic [15:0] y_effective_address = 0, mem_x_rdata, mem_y_rdata, x_rdata, y_rdata;
	logic [15:0] pointer_updated, mem_x_wdata, rm [0:32767], qx[$], qy[$];
	prefetch_ptr_t y_ptr_sel = PTR_X_FIRST, x_ptr_sel = PTR_X_FIRST;
	logic [14:0] mem_x_word_addr, mem_y_word_addr;
	logic mem_x_rd, mem_y_rd, x_rvalid, y_rvalid, address_error_trap;
	logic [1:0] mem_x_lane_we;
	logic [31:0] s = 32'h73f81b97;
	int failures = 0, n_checks = 0;
	always #2 sys_clk = ~sys_clk;
	data_space_access_align data_space_access_align_inst (.*);
	data_mem_model data_mem_model_inst (.*);
	function automatic logic [31:0] xs();
		s ^= s << 13;
		s ^= s >> 17;
		s ^= s << 5;
		return s;
	endfunction
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		logic [31:0] r, q;
		logic [15:0] a, w;
		logic wr, by, pf, on;
		for (int i = 0; i < 32768; i++) rm[i] = 16'(i * 40503);
		repeat (16) @(posedge sys_clk);
		rst_n <= 1'b1;
		for (int c = 0; c < 800; c++) begin
			@(posedge sys_clk);
			r = xs();
			q = xs();
			on = c < 796;
			a = {r[16], 3'h0, r[11:0]}; // covers low x, y, unimplemented and high x space; x sends odd words to reach traps
			w = q[31:16];
			wr = r[17] && a < 16'h0c00;
			pf = r[19] && !wr;
			by = r[18] && !pf;
			// y expectation first: a same-cycle x write lands later
			if (on && q[12]) qy.push_back(q[14] && q[11:10] == 2'b10 ? rm[q[11:1]] : 16'h0);
			if (on && r[22]) begin
				if (!wr) qx.push_back((!a[15] && a >= 16'h0c00) ||
					(pf && ((a[15:10] == 6'h02) == !r[21])) ?
					16'h0 : by ? {8'h0, a[0] ? rm[a[15:1]][15:8] : rm[a[15:1]][7:0]} :
					rm[a[15:1]]);
				else if (by && a[0]) rm[a[15:1]][15:8] = w[7:0];
				else if (by) rm[a[15:1]][7:0] = w[7:0];
				else if (!a[0]) rm[a[15:1]] = w;
			end
			x_req <= on && r[22];
			x_write <= wr;
			x_byte <= by;
			x_effective_address <= a;
			x_wdata <= w;
			source_pointer_register <= q[15:0];
			x_post_inc <= r[23];
			x_prefetch <= pf;
			x_ptr_sel <= prefetch_ptr_t'(r[21:20]);
			y_req <= on && q[12];
			y_effective_address <= {4'h0, q[11:0]};
			y_ptr_sel <= prefetch_ptr_t'(q[14:13]);
			#1;
			if (x_rvalid === 1'b1) chk(x_rdata, qx.pop_front());
			if (y_rvalid === 1'b1) chk(y_rdata, qy.pop_front());
		end
		chk(16'(qx.size() + qy.size()), 16'h0);
		results();
	end
endmodule // testbench
bind data_space_access_align dsa_properties dsa_properties_inst (.*);
